// File: common/rst_src_pkg.sv
`default_nettype none
package rst_src_pkg;
   localparam int CLK_PERIOD_NS    = 10;
   localparam int HOLD_TIME_NS     = 100;
   localparam int HOLD_CYCLES      = (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] HOLD_LAST = 4'(HOLD_CYCLES - 1);
   localparam int CLK_LOSS_TIME_NS = 500;
   localparam int CLK_LOSS_CYCLES  = CLK_LOSS_TIME_NS / CLK_PERIOD_NS;
   localparam int CL_W             = 6;
   localparam int WDOG_TICKS       = 256;
   localparam int WD_W             = 8;
   localparam logic [3:0] DIV_LAST = 4'hb;

   // Register indices; byte address is four times the index
   localparam logic [11:0] SMC_IDX  = 12'h0ff;
   localparam logic [11:0] RCR_IDX  = 12'h0ef;
   localparam logic [11:0] WDC_IDX  = 12'h0f0;
   localparam logic [11:0] SMC_ADDR = {SMC_IDX[9:0], 2'h0};
   localparam logic [11:0] RCR_ADDR = {RCR_IDX[9:0], 2'h0};
   localparam logic [11:0] WDC_ADDR = {WDC_IDX[9:0], 2'h0};

   localparam int MON_EN_BIT   = 7;
   localparam int MON_STAT_BIT = 6;
   localparam int C_PIN = 0;
   localparam int C_PWR = 1;
   localparam int C_CLK = 2;
   localparam int C_WDG = 3;
   localparam int C_SW  = 4;
   localparam int C_CMP = 5;
   localparam int C_FLS = 6;
   localparam int WD_KICK_BIT = 0;
   localparam int WD_DIS_BIT  = 1;

   localparam logic [6:0] CAUSE_POR   = 7'h02;
   localparam logic       MON_EN_POR  = 1'h1;
   localparam logic       MON_SEL_POR = 1'h1;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {ST_RUN, ST_HOLD} seq_state_t;
endpackage : rst_src_pkg
`default_nettype wire

// File: src/timeout_counter.sv
`default_nettype none
module timeout_counter #(
   parameter int W     = 8,
   parameter int LIMIT = 8
) (
   input  wire logic clk,      // System clock
   input  wire logic rst,      // Async reset, high
   input  wire logic en,       // Counting allowed
   input  wire logic tick,     // Count enable pulse
   input  wire logic restart,  // Retrigger
   output logic      expired   // One-cycle timeout pulse
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         exp;
   } tc_state_t;

   tc_state_t q;
   tc_state_t n;

   always_comb begin
      n     = q;
      n.exp = 1'h0;
      if (restart || !en) begin
         n.cnt = '0;
      end else if (tick) begin
         if (q.cnt == W'(LIMIT - 1)) begin
            n.cnt = '0;
            n.exp = 1'h1;
         end else begin
            n.cnt = q.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign expired = q.exp;
endmodule : timeout_counter
`default_nettype wire

// File: src/reset_source_control.sv
`default_nettype none
// Summary of operation
// - Monitor enable bit 7 powers the supply monitor off at 0, on at 1.
// - Enabled monitor resets only when also selected in the cause register.
// - Status bit 6 shows live monitor output, 1 when supply above threshold.
// - Monitor control bits 5:0 read zero; writes to them are ignored.
// - Reset is entered while the external pin is held low.
// - Leaving a pin reset sets pin flag bit 0.
// - Clock loss detector retriggers on clock edges; resets on a stall.
// - Bit 2 reads 1 only after a clock loss reset.
// - Writing bit 2 enables or disables the clock loss detector.
// - Non-supply reset sources never drive the reset pin.
// - Writing 1 to bit 5 selects the comparator as reset source.
// - Selected comparator with low output holds the device in reset.
// - Comparator flag reads 1 only after a comparator reset.
// - Watchdog runs on clock over twelve after reset; expiry resets, flags.
// - Illegal flash accesses reset the device; a write or erase attempt only while the monitor is off.
// - Flash fault reset sets flag bit 6.
// - Writing 1 to bit 4 forces reset; bit 4 then reads 1.
// - Power or monitor reset sets power flag; others clear it.
// - Monitor enabled at power-on, unchanged by every other reset.
module reset_source_control
   import rst_src_pkg::*;
(
   input  wire logic        SYS_CLK,          // System clock
   input  wire logic        RST,              // Power-on reset, async high
   input  wire logic [11:0] AWADDR,           // Write address
   input  wire logic        AWVALID,          // Write address valid
   output logic             AWREADY,          // Write address ready
   input  wire logic [31:0] WDATA,            // Write data
   input  wire logic [3:0]  WSTRB,            // Write byte lanes
   input  wire logic        WVALID,           // Write data valid
   output logic             WREADY,           // Write data ready
   output logic [1:0]       BRESP,            // Write response
   output logic             BVALID,           // Write response valid
   input  wire logic        BREADY,           // Write response ready
   input  wire logic [11:0] ARADDR,           // Read address
   input  wire logic        ARVALID,          // Read address valid
   output logic             ARREADY,          // Read address ready
   output logic [31:0]      RDATA,            // Read data
   output logic [1:0]       RRESP,            // Read response
   output logic             RVALID,           // Read data valid
   input  wire logic        RREADY,           // Read data ready
   input  wire logic        RST_PIN_I,        // Reset pin level
   output logic             RST_PIN_O,        // Reset pin drive value
   output logic             RST_PIN_OE_N,     // Reset pin drive, low drives
   input  wire logic        SUPPLY_ABOVE,     // Monitor output, 1 above threshold
   output logic             SUPPLY_MON_EN,    // Monitor circuit power
   input  wire logic        COMP_OUT,         // Comparator zero output
   input  wire logic        CORE_CLK_LVL,     // Watched clock level
   input  wire logic        FLASH_PROG_OVER,  // Programmer write above user space
   input  wire logic        FLASH_READ_OVER,  // Code read above user space
   input  wire logic        FLASH_FETCH_OVER, // Branch above user space
   input  wire logic        FLASH_SEC_BLOCK,  // Access blocked by security
   input  wire logic        FLASH_WRITE_TRY,  // Flash write or erase attempt
   output logic             SYS_RST           // System reset, high
);
   typedef struct packed {
      seq_state_t  st;
      logic [3:0]  hold_cnt;
      logic        sys_rst;
      logic        pin_oe_n;
      logic        mon_en;
      logic        mon_sel;
      logic        comp_sel;
      logic        cl_en;
      logic        wd_dis;
      logic        wd_kick;
      logic        sw_req;
      logic [6:0]  cause;
      logic [6:0]  flags;
      logic [3:0]  div;
      logic        tick;
      logic        clk_lvl;
      logic        aw_got;
      logic        w_got;
      logic [11:0] aw_addr;
      logic [7:0]  w_data;
      logic        w_lane0;
      logic        aw_rdy;
      logic        w_rdy;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        ar_rdy;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
   } rsc_state_t;

   // Power-on looks like a supply reset: pin driven, power flag pending
   localparam rsc_state_t RESET_STATE = '{
      st:       ST_HOLD,
      sys_rst:  1'h1,
      mon_en:   MON_EN_POR,
      mon_sel:  MON_SEL_POR,
      cl_en:    1'h1,
      cause:    CAUSE_POR,
      flags:    CAUSE_POR,
      aw_rdy:   1'h1,
      w_rdy:    1'h1,
      ar_rdy:   1'h1,
      default:  '0
   };

   rsc_state_t q;
   rsc_state_t n;

   logic       aw_fire;
   logic       w_fire;
   logic       ar_fire;
   logic       wr_go;
   logic       wr_smc;
   logic       wr_rcr;
   logic       wr_wdc;
   logic       wr_hit;
   logic       pin_src;
   logic       sup_src;
   logic       cmp_src;
   logic       fls_src;
   logic       cl_exp;
   logic       wd_exp;
   logic [6:0] src;
   logic       src_any;

   assign aw_fire = AWVALID && q.aw_rdy;
   assign w_fire  = WVALID && q.w_rdy;
   assign ar_fire = ARVALID && q.ar_rdy;
   assign wr_go   = q.aw_got && q.w_got && !q.bvalid;
   assign wr_hit  = (q.aw_addr == SMC_ADDR) || (q.aw_addr == RCR_ADDR) || (q.aw_addr == WDC_ADDR);
   // Lane 0 holds every register bit; other lanes are ignored
   assign wr_smc  = wr_go && q.w_lane0 && (q.aw_addr == SMC_ADDR);
   assign wr_rcr  = wr_go && q.w_lane0 && (q.aw_addr == RCR_ADDR);
   assign wr_wdc  = wr_go && q.w_lane0 && (q.aw_addr == WDC_ADDR);

   // Own drive masked, else our pin pull-down would latch as a pin reset
   assign pin_src = !RST_PIN_I && q.pin_oe_n;
   assign sup_src = q.mon_en && q.mon_sel && !SUPPLY_ABOVE;
   assign cmp_src = q.comp_sel && !COMP_OUT;
   assign fls_src = FLASH_PROG_OVER || FLASH_READ_OVER || FLASH_FETCH_OVER
                    || FLASH_SEC_BLOCK || (FLASH_WRITE_TRY && !q.mon_en);
   assign src     = {fls_src, cmp_src, q.sw_req, wd_exp, cl_exp, sup_src, pin_src};
   assign src_any = |src;

   timeout_counter #(
      .W     (CL_W),
      .LIMIT (CLK_LOSS_CYCLES)
   ) u_clk_loss (
      .clk     (SYS_CLK),
      .rst     (RST),
      .en      (q.cl_en && (q.st == ST_RUN)),
      .tick    (1'h1),
      .restart (CORE_CLK_LVL != q.clk_lvl),
      .expired (cl_exp)
   );

   timeout_counter #(
      .W     (WD_W),
      .LIMIT (WDOG_TICKS)
   ) u_watchdog (
      .clk     (SYS_CLK),
      .rst     (RST),
      .en      (!q.wd_dis && (q.st == ST_RUN)),
      .tick    (q.tick),
      .restart (q.wd_kick),
      .expired (wd_exp)
   );

   always_comb begin
      n         = q;
      n.wd_kick = 1'h0;
      n.sw_req  = 1'h0;
      n.clk_lvl = CORE_CLK_LVL;
      n.tick    = (q.div == DIV_LAST);
      n.div     = n.tick ? 4'h0 : q.div + 4'h1;

      if (aw_fire) begin
         n.aw_got  = 1'h1;
         n.aw_addr = AWADDR;
      end
      if (w_fire) begin
         n.w_got   = 1'h1;
         n.w_data  = WDATA[7:0];
         n.w_lane0 = WSTRB[0];
      end
      if (wr_go) begin
         n.aw_got = 1'h0;
         n.w_got  = 1'h0;
         n.bvalid = 1'h1;
         n.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (q.bvalid && BREADY) begin
         n.bvalid = 1'h0;
      end
      n.aw_rdy = !n.aw_got && !n.bvalid;
      n.w_rdy  = !n.w_got && !n.bvalid;

      if (wr_smc) begin
         n.mon_en = q.w_data[MON_EN_BIT];
      end
      if (wr_rcr) begin
         n.mon_sel  = q.w_data[C_PWR];
         n.cl_en    = q.w_data[C_CLK];
         n.comp_sel = q.w_data[C_CMP];
         n.sw_req   = q.w_data[C_SW];
      end
      if (wr_wdc) begin
         n.wd_kick = q.w_data[WD_KICK_BIT];
         n.wd_dis  = q.w_data[WD_DIS_BIT];
      end

      if (ar_fire) begin
         n.rvalid = 1'h1;
         n.rresp  = RESP_OKAY;
         case (ARADDR)
            SMC_ADDR: n.rdata = {q.mon_en, SUPPLY_ABOVE, 6'h00};
            RCR_ADDR: n.rdata = {1'h0, q.flags};
            WDC_ADDR: n.rdata = {6'h00, q.wd_dis, 1'h0};
            default: begin
               n.rdata = 8'h00;
               n.rresp = RESP_SLVERR;
            end
         endcase
      end else if (q.rvalid && RREADY) begin
         n.rvalid = 1'h0;
      end
      n.ar_rdy = !n.rvalid;

      case (q.st)
         ST_RUN: begin
            if (src_any) begin
               n.st       = ST_HOLD;
               n.hold_cnt = 4'h0;
               n.cause    = src;
               n.sys_rst  = 1'h1;
            end
         end
         ST_HOLD: begin
            // Sources seen at any time in the hold all count as causes
            n.cause = q.cause | src;
            if (q.hold_cnt != HOLD_LAST) begin
               n.hold_cnt = q.hold_cnt + 4'h1;
            end else if (!src_any) begin
               n.st       = ST_RUN;
               n.sys_rst  = 1'h0;
               // Power cause hides the rest; mon_en deliberately untouched
               n.flags    = q.cause[C_PWR] ? CAUSE_POR : q.cause;
               n.comp_sel = 1'h0;
               n.cl_en    = 1'h1;
               n.wd_dis   = 1'h0;
            end
         end
         default: begin
            n.st      = ST_HOLD;
            n.sys_rst = 1'h1;
         end
      endcase
      // Only power-on and supply resets pull the pin
      n.pin_oe_n = !((n.st == ST_HOLD) && n.cause[C_PWR]);
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         q <= RESET_STATE;
      end else begin
         q <= n;
      end
   end

   assign AWREADY       = q.aw_rdy;
   assign WREADY        = q.w_rdy;
   assign BVALID        = q.bvalid;
   assign BRESP         = q.bresp;
   assign ARREADY       = q.ar_rdy;
   assign RVALID        = q.rvalid;
   assign RRESP         = q.rresp;
   assign RDATA         = {24'h000000, q.rdata};
   assign RST_PIN_O     = 1'h0;
   assign RST_PIN_OE_N  = q.pin_oe_n;
   assign SUPPLY_MON_EN = q.mon_en;
   assign SYS_RST       = q.sys_rst;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   sequence s_exit;
      $fell(q.sys_rst);
   endsequence
   sequence s_tick_gap;
      (!q.tick) [*8] ##1 (!q.tick) [*3] ##1 q.tick;
   endsequence

   property p_mon_power;
      wr_smc |=> (SUPPLY_MON_EN == $past(q.w_data[MON_EN_BIT]));
   endproperty
   a_mon_power: assert property (p_mon_power)
      else $error("monitor power does not follow its enable bit");

   property p_sup_gate;
      ((q.st == ST_RUN) && !src_any) |=> !SYS_RST;
   endproperty
   a_sup_gate: assert property (p_sup_gate)
      else $error("reset raised with no selected source");

   property p_status;
      (ar_fire && (ARADDR == SMC_ADDR)) |=>
         ((RDATA[MON_STAT_BIT] == $past(SUPPLY_ABOVE)) && (RDATA[5:0] == 6'h00));
   endproperty
   a_status: assert property (p_status)
      else $error("monitor control read wrong");

   property p_pin_in;
      ((q.st == ST_RUN) && !RST_PIN_I && RST_PIN_OE_N) |=> SYS_RST;
   endproperty
   a_pin_in: assert property (p_pin_in)
      else $error("low pin did not reset");

   property p_flags;
      s_exit |-> (q.flags == ($past(q.cause[C_PWR]) ? CAUSE_POR : $past(q.cause)));
   endproperty
   a_flags: assert property (p_flags)
      else $error("cause flags wrong on reset exit");

   property p_event;
      ((q.st == ST_RUN) && (cl_exp || wd_exp || fls_src || cmp_src)) |=> SYS_RST;
   endproperty
   a_event: assert property (p_event)
      else $error("reset source did not reset");

   property p_enables;
      (wr_rcr && (q.st == ST_RUN)) |=>
         ((q.cl_en == $past(q.w_data[C_CLK])) && (q.comp_sel == $past(q.w_data[C_CMP])));
   endproperty
   a_enables: assert property (p_enables)
      else $error("cause register enables not stored");

   property p_pin_quiet;
      ((q.st == ST_HOLD) && !q.cause[C_PWR]) |-> RST_PIN_OE_N;
   endproperty
   a_pin_quiet: assert property (p_pin_quiet)
      else $error("pin driven by a non-supply reset");

   property p_soft;
      (wr_rcr && q.w_data[C_SW]) |-> ##2 SYS_RST;
   endproperty
   a_soft: assert property (p_soft)
      else $error("software reset not forced");

   property p_wd_div;
      q.tick |=> s_tick_gap;
   endproperty
   a_wd_div: assert property (p_wd_div)
      else $error("watchdog tick not one in twelve");

   property p_wd_on;
      s_exit |-> !q.wd_dis;
   endproperty
   a_wd_on: assert property (p_wd_on)
      else $error("watchdog not enabled after reset");

   property p_mon_keep;
      ((q.st == ST_HOLD) && !wr_smc) |=> (q.mon_en == $past(q.mon_en));
   endproperty
   a_mon_keep: assert property (p_mon_keep)
      else $error("monitor enable changed by reset");
endmodule : reset_source_control
`default_nettype wire

// File: bench/ext_reset_drv.sv
`default_nettype none
module ext_reset_drv (
   input  wire logic       clk,      // System clock
   input  wire logic       go,       // Start a low pulse
   input  wire logic [7:0] len,      // Pulse length in cycles
   output logic            pull_low  // High pulls the pin low
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] left_ff = 8'h00;
   always @(posedge clk) begin
      if (go) begin
         left_ff <= len;
      end else if (left_ff != 8'h00) begin
         left_ff <= left_ff - 8'h01;
      end
   end
   // Released pin floats up through the board pull-up
   assign pull_low = (left_ff != 8'h00);
endmodule : ext_reset_drv
`default_nettype wire

// File: bench/reset_source_control_tb.sv
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module reset_source_control_tb;
   import rst_src_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk      = 1'b0;
   logic        rst          = 1'b1;
   logic [11:0] awaddr       = 12'h000;
   logic [11:0] araddr       = 12'h000;
   logic [31:0] wdata        = 32'h0;
   logic [3:0]  wstrb        = 4'h0;
   logic        awvalid      = 1'b0;
   logic        wvalid       = 1'b0;
   logic        bready       = 1'b0;
   logic        arvalid      = 1'b0;
   logic        rready       = 1'b0;
   logic        supply_above = 1'b1;
   logic        comp_out     = 1'b1;
   logic        core_clk_lvl = 1'b0;
   logic        clk_run      = 1'b1;
   logic [4:0]  flash        = 5'h00;
   logic        go           = 1'b0;
   logic [7:0]  len          = 8'h00;
   logic        awready, wready, bvalid, arready, rvalid, rst_pin_o, rst_pin_oe_n, supply_mon_en, sys_rst;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   wire logic   pull_low;
   wire logic   rst_pin_i;
   int          miscompares = 0;
   int          n_checks    = 0;
   int          m_mon_en    = 1;

   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (clk_run) core_clk_lvl <= ~core_clk_lvl;
   assign rst_pin_i = !(pull_low || (rst_pin_oe_n === 1'b0 && rst_pin_o === 1'b0));

   ext_reset_drv ext (.clk(sys_clk), .go(go), .len(len), .pull_low(pull_low));

   reset_source_control dut (
      .SYS_CLK(sys_clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .RST_PIN_I(rst_pin_i),
      .RST_PIN_O(rst_pin_o), .RST_PIN_OE_N(rst_pin_oe_n), .SUPPLY_ABOVE(supply_above),
      .SUPPLY_MON_EN(supply_mon_en), .COMP_OUT(comp_out), .CORE_CLK_LVL(core_clk_lvl),
      .FLASH_PROG_OVER(flash[0]), .FLASH_READ_OVER(flash[1]), .FLASH_FETCH_OVER(flash[2]),
      .FLASH_SEC_BLOCK(flash[3]), .FLASH_WRITE_TRY(flash[4]), .SYS_RST(sys_rst));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick

   task automatic timeout_if(input logic bad);
      if (bad) begin
         miscompares++;
         stop_test();
      end
   endtask : timeout_if

   function automatic logic [7:0] smc_exp();
      return {1'(m_mon_en), supply_above, 6'h00};
   endfunction : smc_exp

   // Callers enter right after a rising edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] resp = RESP_OKAY);
      int n;
      n = 0;
      awaddr  <= a;
      wdata   <= {24'($urandom), d};
      wstrb   <= {3'($urandom), 1'b1};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 200);
      bready <= 1'b0;
      timeout_if(n >= 200);
      `CHK(bresp, resp)
      // One idle edge so a following call never re-raises bready in this step
      @(posedge sys_clk);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] resp);
      int n;
      n = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 200);
      rready <= 1'b0;
      timeout_if(n >= 200);
      `CHK(rdata, {24'h0, exp})
      `CHK(rresp, resp)
      @(posedge sys_clk);
   endtask : rd

   // Waits out one reset, noting whether the device pulled the pin
   task automatic reset_cycle(input logic [7:0] exp, input logic drive);
      int   n;
      logic drove;
      n     = 0;
      drove = 1'b0;
      while (sys_rst !== 1'b1 && n < 4000) begin
         @(posedge sys_clk);
         n++;
      end
      timeout_if(sys_rst !== 1'b1);
      while (sys_rst !== 1'b0 && n < 8000) begin
         @(posedge sys_clk);
         n++;
         if (rst_pin_oe_n === 1'b0) drove = 1'b1;
      end
      timeout_if(sys_rst !== 1'b0);
      `CHK(drove, drive)
      rd(RCR_ADDR, exp, RESP_OKAY);
   endtask : reset_cycle

   task automatic fpulse(input int i);
      flash[i] <= 1'b1;
      @(posedge sys_clk);
      flash[i] <= 1'b0;
   endtask : fpulse

   initial begin
      void'($urandom(32'h5192));
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      reset_cycle(8'h02, 1'b1);
      `CHK(supply_mon_en, 1'b1)
      `CHK(rst_pin_o, 1'b0)
      rd(SMC_ADDR, smc_exp(), RESP_OKAY);
      rd(12'h004, 8'h00, RESP_SLVERR);
      wr(12'h008, 8'hff, RESP_SLVERR);
      wr(SMC_ADDR, 8'h80 | 8'($urandom_range(0, 127)));
      rd(SMC_ADDR, smc_exp(), RESP_OKAY);
      len <= 8'($urandom_range(1, 40));
      go  <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      tick(3);
      `CHK(sys_rst, 1'b1)
      reset_cycle(8'h01, 1'b0);
      wr(RCR_ADDR, 8'h04);
      supply_above <= 1'b0;
      tick(5);
      `CHK(sys_rst, 1'b0)
      rd(SMC_ADDR, smc_exp(), RESP_OKAY);
      supply_above <= 1'b1;
      wr(SMC_ADDR, 8'h00);
      m_mon_en = 0;
      tick(1);
      `CHK(supply_mon_en, 1'b0)
      wr(RCR_ADDR, 8'h14);
      reset_cycle(8'h10, 1'b0);
      rd(SMC_ADDR, smc_exp(), RESP_OKAY);
      fpulse(4);
      reset_cycle(8'h40, 1'b0);
      wr(SMC_ADDR, 8'h80);
      m_mon_en = 1;
      tick(20); // Monitor settles before it is selected
      wr(RCR_ADDR, 8'h06);
      fpulse(4);
      tick(5);
      `CHK(sys_rst, 1'b0)
      for (int i = 0; i < 4; i++) begin
         fpulse(i);
         reset_cycle(8'h40, 1'b0);
      end
      supply_above <= 1'b0;
      tick(15);
      `CHK(sys_rst, 1'b1)
      supply_above <= 1'b1;
      reset_cycle(8'h02, 1'b1);
      comp_out <= 1'b0;
      tick(5); // Comparator already settled when selected
      `CHK(sys_rst, 1'b0)
      wr(RCR_ADDR, 8'h26);
      tick(30);
      `CHK(sys_rst, 1'b1)
      comp_out <= 1'b1;
      reset_cycle(8'h20, 1'b0);
      clk_run <= 1'b0;
      tick(56);
      `CHK(sys_rst, 1'b1)
      clk_run <= 1'b1;
      reset_cycle(8'h04, 1'b0);
      wr(RCR_ADDR, 8'h02);
      clk_run <= 1'b0;
      tick(80);
      `CHK(sys_rst, 1'b0)
      clk_run <= 1'b1;
      reset_cycle(8'h08, 1'b0);
      tick(2000);
      wr(WDC_ADDR, 8'h01);
      tick(2000);
      `CHK(sys_rst, 1'b0)
      wr(WDC_ADDR, 8'h02);
      rd(WDC_ADDR, 8'h02, RESP_OKAY);
      wr(RCR_ADDR, 8'h12);
      reset_cycle(8'h10, 1'b0);
      rd(WDC_ADDR, 8'h00, RESP_OKAY);
      stop_test();
   end
endmodule : reset_source_control_tb
`default_nettype wire
